//--- hdl/mcrs_clock_reset.sv
// Purpose: Clock and reset distribution for a memory interface PHY
// Assumes: ref_clk at 25 MHz stands in for the PLL memory clock output
// Notes: Clocks leave as registered toggles; one file holds all the logic
// Overview of operation
// - Global reset low clears the PLL model and all PHY logic asynchronously.
// - Soft reset low clears PHY logic but leaves the PLL running.
// - Master mode drives controller reset low on lost lock or PHY reset.
// - Interface clock runs at full or half memory rate, fixed at build.
// - A secondary clock runs at exactly half the interface clock.
// - Master mode generates the interface clock and drives it out.
// - Hard interface option gives command, read and write front-end FIFOs.
// - Each front-end FIFO has its own clock and reset input.
// - Bonding export gives three inputs and three outputs, cross-connected.
`timescale 1ns/1ps
`default_nettype none
`include "mcrs_defs.svh"

module mcrs_clock_reset
   import mcrs_pkg::*;
#(
   parameter mcrs_mode_type MODE = MCRS_MASTER,
   parameter mcrs_rate_type RATE = MCRS_HALF_RATE,
   parameter bit HARD_IF = 1'b1,
   parameter bit BOND_EXPORT = 1'b1
)(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic globalResetN,
   input wire logic softResetN,
   input wire logic pllLocked,
   input wire logic ifClkIn,
   input wire logic ifHalfClkIn,
   input wire logic ifResetInN,
   output logic ifClkOut,
   output logic ifHalfClkOut,
   output logic ifResetOutN,
   output logic ifClk,
   output logic ifHalfClk,
   output logic ifResetN,
   input wire mcrs_fifo_clk_type frontEndFifoClk,
   input wire mcrs_fifo_rst_type frontEndFifoRst,
   output mcrs_fifo_clk_type fifoClkOut,
   output mcrs_fifo_rst_type fifoRstOut,
   input wire logic [`MCRS_BOND_W-1:0] bondIn,
   input wire logic [`MCRS_BOND_W-1:0] coreBondOut,
   output logic [`MCRS_BOND_W-1:0] bondOut,
   output logic [`MCRS_BOND_W-1:0] coreBondIn
);
   // Combined async resets: global hits everything, soft only the PHY
   logic pllRstN;
   logic phyRstN;
   assign pllRstN = rstn & globalResetN;
   assign phyRstN = pllRstN & softResetN;

   // PLL model: divider state lives in the PLL domain, untouched by soft reset
   logic [1:0] divCnt_q, divCnt_d;
   logic clk_q, clk_d;
   logic half_q, half_d;
   always_comb begin
      divCnt_d = divCnt_q + 2'h1;
      clk_d = clk_q;
      half_d = half_q;
      if (RATE == MCRS_FULL_RATE) begin
         clk_d = ~clk_q;
         if (!clk_q) begin
            half_d = ~half_q;
         end
      end else begin
         if (divCnt_q[0]) begin
            clk_d = ~clk_q;
         end
         // Toggle only where the interface clock rises, so half rises stay aligned
         if (divCnt_q == 2'h1) begin
            half_d = ~half_q;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge pllRstN) begin
      if (!pllRstN) begin
         divCnt_q <= `MCRS_DIV_FULL;
         clk_q <= 1'b0;
         half_q <= 1'b0;
      end else begin
         divCnt_q <= divCnt_d;
         clk_q <= clk_d;
         half_q <= half_d;
      end
   end

   // Lock synchroniser, cleared with the PHY so a reset forces a fresh wait
   logic lockMeta_q, lockSync_q;
   always_ff @(posedge ref_clk or negedge phyRstN) begin
      if (!phyRstN) begin
         lockMeta_q <= 1'b0;
         lockSync_q <= 1'b0;
      end else begin
         lockMeta_q <= pllLocked;
         lockSync_q <= lockMeta_q;
      end
   end

   // Reset sequencer: hold a few cycles, then wait for lock
   mcrs_rst_state_type st_q, st_d;
   logic [`MCRS_RST_CNT_W-1:0] cnt_q, cnt_d;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         MCRS_RST_HOLD_ST: begin
            if (cnt_q == `MCRS_RST_HOLD) begin
               st_d = MCRS_RST_WAIT_LOCK;
            end else begin
               cnt_d = cnt_q + 4'h1;
            end
         end
         MCRS_RST_WAIT_LOCK: begin
            if (lockSync_q) begin
               st_d = MCRS_RST_RUN;
            end
         end
         MCRS_RST_RUN: begin
            // Raw lock too, so a short drop cannot let the output rise again early
            if (!lockSync_q || !pllLocked) begin
               st_d = MCRS_RST_HOLD_ST;
               cnt_d = '0;
            end
         end
         default: begin
            st_d = MCRS_RST_HOLD_ST;
            cnt_d = '0;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge phyRstN) begin
      if (!phyRstN) begin
         st_q <= MCRS_RST_HOLD_ST;
         cnt_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // Reset register takes the next state, so it drops on the first ref_clk edge after lost lock
   logic rstOut_q;
   always_ff @(posedge ref_clk or negedge phyRstN) begin
      if (!phyRstN) begin
         rstOut_q <= 1'b0;
      end else begin
         rstOut_q <= (st_d == MCRS_RST_RUN);
      end
   end

   // Master drives clocks and reset out; slave takes them from the master
   always_comb begin
      if (MODE == MCRS_MASTER) begin
         ifClkOut = clk_q;
         ifHalfClkOut = half_q;
         ifResetOutN = rstOut_q & pllLocked & phyRstN;
         ifClk = clk_q;
         ifHalfClk = half_q;
         ifResetN = ifResetOutN;
      end else begin
         ifClkOut = 1'b0;
         ifHalfClkOut = 1'b0;
         ifResetOutN = 1'b0;
         ifClk = ifClkIn;
         ifHalfClk = ifHalfClkIn;
         ifResetN = ifResetInN & phyRstN;
      end
   end

   // Front-end FIFO clocks and resets pass on independently per FIFO
   always_comb begin
      if (HARD_IF) begin
         fifoClkOut = frontEndFifoClk;
         fifoRstOut = frontEndFifoRst;
      end else begin
         fifoClkOut = '0;
         fifoRstOut = '0;
      end
   end

   // Bonding: peer inputs feed our core, our core feeds the peer
   always_comb begin
      if (BOND_EXPORT) begin
         coreBondIn = bondIn;
         bondOut = coreBondOut;
      end else begin
         coreBondIn = '0;
         bondOut = '0;
      end
   end

   // Checks
   chk_half_rise_align: assert property (@(posedge ref_clk) disable iff (!pllRstN)
      (MODE == MCRS_MASTER && $rose(ifHalfClkOut)) |-> $rose(ifClkOut))
      else $error("half clock rose without interface clock");
   chk_half_period: assert property (@(posedge ref_clk) disable iff (!pllRstN)
      (MODE == MCRS_MASTER && RATE == MCRS_HALF_RATE && $rose(ifHalfClkOut)) |-> ##8 $rose(ifHalfClkOut))
      else $error("half clock period wrong");
   chk_clk_half_rate: assert property (@(posedge ref_clk) disable iff (!pllRstN)
      (MODE == MCRS_MASTER && RATE == MCRS_HALF_RATE && $rose(ifClkOut)) |-> ##1 ifClkOut ##1 !ifClkOut)
      else $error("interface clock rate wrong");
   chk_clk_toggles: assert property (@(posedge ref_clk) disable iff (!pllRstN)
      (MODE == MCRS_MASTER) |-> ##[1:2] (ifClkOut != $past(ifClkOut)))
      else $error("interface clock stopped");
   chk_lock_drop_rst: assert property (@(posedge ref_clk) disable iff (!phyRstN)
      (MODE == MCRS_MASTER && !pllLocked) |-> !ifResetOutN)
      else $error("reset out high without lock");
   chk_rst_release: assert property (@(posedge ref_clk) disable iff (!phyRstN)
      (MODE == MCRS_MASTER && $rose(ifResetOutN)) |-> $past(lockSync_q))
      else $error("reset released before lock");
   chk_soft_keeps_pll: assert property (@(posedge ref_clk) disable iff (!pllRstN)
      (!softResetN && MODE == MCRS_MASTER) |-> ##2 (ifClkOut != $past(ifClkOut, 2)) or ##1 (ifClkOut != $past(ifClkOut)))
      else $error("soft reset stopped the clock");
   chk_global_clears: assert property (@(posedge ref_clk)
      (!globalResetN) |-> (divCnt_q == `MCRS_DIV_FULL && st_q == MCRS_RST_HOLD_ST))
      else $error("global reset did not clear");
   chk_bond_pass: assert property (@(posedge ref_clk) disable iff (!phyRstN)
      BOND_EXPORT |-> (bondOut == coreBondOut && coreBondIn == bondIn))
      else $error("bonding not cross connected");
endmodule
`default_nettype wire

//--- hdl/mcrs_defs.svh
// Purpose: Constants for the memory interface clock and reset sharing block
// Assumes: Included by bare name
// Notes: Sync depth, divider reset values, reset hold count and widths
`ifndef MCRS_DEFS_SVH
`define MCRS_DEFS_SVH
`define MCRS_SYNC_STAGES 2
`define MCRS_DIV_FULL 2'h0
`define MCRS_DIV_HALF 2'h1
`define MCRS_RST_CNT_W 4
`define MCRS_RST_HOLD 4'h3
`define MCRS_BOND_W 3
`endif

//--- hdl/mcrs_pkg.sv
// Purpose: Types for the clock and reset sharing block
// Assumes: Nothing beyond the defs header
// Notes: Types only
package mcrs_pkg;
   typedef enum logic {MCRS_MASTER, MCRS_SLAVE} mcrs_mode_type;
   typedef enum logic {MCRS_FULL_RATE, MCRS_HALF_RATE} mcrs_rate_type;
   typedef enum logic [1:0] {MCRS_RST_HOLD_ST, MCRS_RST_WAIT_LOCK, MCRS_RST_RUN} mcrs_rst_state_type;
   typedef struct packed {
      logic cmdClk;
      logic readClk;
      logic writeClk;
   } mcrs_fifo_clk_type;
   typedef struct packed {
      logic cmdRst;
      logic readRst;
      logic writeRst;
   } mcrs_fifo_rst_type;
endpackage

//--- dv/mcrs_peer_model.sv
// Purpose: Peer interface instance in master mode, feeding slave inputs
// Assumes: Shares the reference clock and reset with the bench
// Notes: Clocks free-run from one counter, so both rise together
`timescale 1ns/1ps
`default_nettype none
module mcrs_peer_model (
   input wire logic refClk,
   input wire logic rstN,
   input wire logic locked,
   output logic clkOut,
   output logic halfOut,
   output logic resetOutN
);
   logic [2:0] divQ;
   // One counter for both dividers keeps their rising edges aligned
   always_ff @(posedge refClk or negedge rstN) begin
      if (!rstN) begin
         divQ <= 3'h0;
      end else begin
         divQ <= divQ + 3'h1;
      end
   end
   assign clkOut = ~divQ[1];
   assign halfOut = ~divQ[2];
   assign resetOutN = rstN & locked;
endmodule
`default_nettype wire

//--- dv/mcrs_clock_reset_tb_top.sv
// Purpose: Self-checking bench for the clock and reset sharing block
// Assumes: Half rate; master build with hard interface and bonding on, slave build with both off
// Notes: Expected periods come from the rate choice, not the design
`timescale 1ns/1ps
`default_nettype none
`include "mcrs_defs.svh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %0h seen %0h", n, e, a); end end
module mcrs_clock_reset_tb_top;
   import mcrs_pkg::*;
   localparam mcrs_rate_type Rate = MCRS_HALF_RATE;
   localparam int ClkPer = (Rate == MCRS_HALF_RATE) ? 4 : 2;
   logic ref_clk = 1'b0, rstn = 1'b0, globalResetN = 1'b1, softResetN = 1'b1, pllLocked = 1'b1;
   logic peerClk, peerHalf, peerRstN, ifClkOut, ifHalfClkOut, ifResetOutN, ifClk, ifHalfClk, ifResetN;
   logic prevC, prevH, p;
   mcrs_fifo_clk_type feClk = '0, fifoClkOut;
   mcrs_fifo_rst_type feRst = '0, fifoRstOut;
   logic [`MCRS_BOND_W-1:0] bondIn = '0, coreBondOut = '0, bondOut, coreBondIn;
   int num_errors = 0, check_count = 0, n;
   int cr[$], hr[$];
   // Slave instance outputs, fed from the peer model
   logic sClkOut, sHalfOut, sRstOut, sClk, sHalf, sRstN;
   mcrs_fifo_clk_type sFifoClk;
   mcrs_fifo_rst_type sFifoRst;
   logic [`MCRS_BOND_W-1:0] sBondOut, sCoreBondIn;
   mcrs_peer_model PEER (.refClk(ref_clk), .rstN(rstn), .locked(pllLocked), .clkOut(peerClk),
      .halfOut(peerHalf), .resetOutN(peerRstN));
   mcrs_clock_reset #(.MODE(MCRS_MASTER), .RATE(Rate), .HARD_IF(1'b1), .BOND_EXPORT(1'b1)) DUT (
      .ref_clk(ref_clk), .rstn(rstn), .globalResetN(globalResetN), .softResetN(softResetN),
      .pllLocked(pllLocked), .ifClkIn(peerClk), .ifHalfClkIn(peerHalf), .ifResetInN(peerRstN),
      .ifClkOut(ifClkOut), .ifHalfClkOut(ifHalfClkOut), .ifResetOutN(ifResetOutN), .ifClk(ifClk),
      .ifHalfClk(ifHalfClk), .ifResetN(ifResetN), .frontEndFifoClk(feClk), .frontEndFifoRst(feRst),
      .fifoClkOut(fifoClkOut), .fifoRstOut(fifoRstOut), .bondIn(bondIn), .coreBondOut(coreBondOut),
      .bondOut(bondOut), .coreBondIn(coreBondIn));
   // Slave build with front end and bonding off exercises the other branches
   mcrs_clock_reset #(.MODE(MCRS_SLAVE), .RATE(Rate), .HARD_IF(1'b0), .BOND_EXPORT(1'b0)) DUT_SLV (
      .ref_clk(ref_clk), .rstn(rstn), .globalResetN(globalResetN), .softResetN(softResetN),
      .pllLocked(pllLocked), .ifClkIn(peerClk), .ifHalfClkIn(peerHalf), .ifResetInN(peerRstN),
      .ifClkOut(sClkOut), .ifHalfClkOut(sHalfOut), .ifResetOutN(sRstOut), .ifClk(sClk),
      .ifHalfClk(sHalf), .ifResetN(sRstN), .frontEndFifoClk(feClk), .frontEndFifoRst(feRst),
      .fifoClkOut(sFifoClk), .fifoRstOut(sFifoRst), .bondIn(bondIn), .coreBondOut(coreBondOut),
      .bondOut(sBondOut), .coreBondIn(sCoreBondIn));
   // Reference clock, 40 ns period
   always #20 ref_clk = ~ref_clk;
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Reset must stay low through the sync stages, then rise in bounded time
   task automatic wait_up;
      tick(2);
      `CHK("rstHeld", 1'b0, ifResetOutN)
      n = 0;
      while (ifResetOutN !== 1'b1 && n < 30) begin
         tick(1);
         n++;
      end
      `CHK("rstUp", 1'b1, ifResetOutN)
   endtask
   // Watchdog sized well past the hundred or so cycles the tests need
   initial begin
      #80000;
      num_errors++;
      tally_and_finish;
   end
   // Main sequence
   initial begin
      void'($urandom(27751));
      tick(6);
      `CHK("rstClk", 1'b0, ifClkOut)
      `CHK("rstOut", 1'b0, ifResetOutN)
      rstn = 1'b1;
      wait_up;
      // Rising edges logged to a queue model, then spacing compared
      prevC = ifClkOut;
      prevH = ifHalfClkOut;
      for (int i = 0; i < 40; i++) begin
         tick(1);
         if (ifClkOut && !prevC) cr.push_back(i);
         if (ifHalfClkOut && !prevH) begin
            hr.push_back(i);
            `CHK("halfAlign", 1'b1, ifClkOut && !prevC)
         end
         `CHK("ifClkSel", ifClkOut, ifClk)
         `CHK("ifHalfSel", ifHalfClkOut, ifHalfClk)
         `CHK("ifRstSel", ifResetOutN, ifResetN)
         `CHK("slvClk", peerClk, sClk)
         `CHK("slvHalf", peerHalf, sHalf)
         `CHK("slvRst", peerRstN, sRstN)
         `CHK("slvOut", 3'h0, {sClkOut, sHalfOut, sRstOut})
         prevC = ifClkOut;
         prevH = ifHalfClkOut;
      end
      `CHK("clkPeriod", ClkPer, cr[2] - cr[1])
      `CHK("halfPeriod", 2 * ClkPer, hr[2] - hr[1])
      pllLocked = 1'b0;
      #1;
      `CHK("lockLost", 1'b0, ifResetOutN)
      `CHK("slvLock", 1'b0, sRstN)
      tick(1);
      pllLocked = 1'b1;
      wait_up;
      // Soft reset drops the reset but the clocks keep toggling
      softResetN = 1'b0;
      tick(1);
      `CHK("softRst", 1'b0, ifResetOutN)
      `CHK("slvSoft", 1'b0, sRstN)
      n = 0;
      for (int i = 0; i < 8; i++) begin
         p = ifClkOut;
         tick(1);
         n += int'(ifClkOut != p);
      end
      `CHK("clkRuns", 16 / ClkPer, n)
      softResetN = 1'b1;
      wait_up;
      globalResetN = 1'b0;
      #1;
      `CHK("glbClk", 1'b0, ifClkOut | ifHalfClkOut)
      `CHK("glbRst", 1'b0, ifResetOutN)
      tick(1);
      globalResetN = 1'b1;
      wait_up;
      // Random per-FIFO clocks, resets and bonding lines pass straight through
      for (int i = 0; i < 16; i++) begin
         {feClk, feRst, bondIn, coreBondOut} = 12'($urandom);
         #1;
         `CHK("fifoClk", feClk, fifoClkOut)
         `CHK("fifoRst", feRst, fifoRstOut)
         `CHK("bondOut", coreBondOut, bondOut)
         `CHK("bondIn", bondIn, coreBondIn)
         `CHK("noFront", 12'h0, {sFifoClk, sFifoRst, sBondOut, sCoreBondIn})
         tick(1);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
